// >>> ccp_cfg_hold.sv
`timescale 1ns/1ns
// holds one configuration byte; loaded once, read data registered
module ccp_cfg_hold
  import ccp_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       load_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o
);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      data_o <= CFG_ERASED;
    end else if (load_i) begin
      data_o <= data_i;
    end
  end

endmodule

// >>> ccp_core.sv
`timescale 1ns/1ns
// Function
// - oscillator type: 00 crystal, 01 rc, 10 reserved, 11 external clock
// - rc frequency select: 0 gives 11.0592 MHz, 1 gives 22.1184 MHz
// - clock output on crystal out pin when enabled with rc or external
// - clock output runs at one quarter of cpu clock
// - clock divide: hi 0 gives 4, 10 gives 64, 11 gives 1024
// - all peripherals but a watchdog set to slow rc are timed from the divided cpu clock
// - power-on flag set after power-up, held until software clears
// - brownout either holds reset or raises interrupt on each crossing
// - low power brownout: while supply low, sense 64 slow rc periods, off 960, repeat; otherwise sense stays on
// - runtime level: hi 0 is 2.6 V, 10 is 3.8 V, 11 is 4.5 V
// - config level: hi 1 is 2.6 V, 01 is 3.8 V, 00 is 4.5 V
// - first byte bit 3 enables brownout detection
// - first byte bit 7 picks watchdog clock: slow rc or cpu clock
// - first byte bit 6: ports reset open-drain when 0, quasi when 1
// - first byte bit 5 sets port reset level; external code needs 1
// - first byte bit 2 enables the input clock filter
// - bytes read from fb00 and fb01 at power-up, fixed afterwards
// - lock bits: 11 open, 01 code locked, 10 unsupported, 00 all locked
// - code lock 0 refuses external access to flash and config
// - read inhibit 0 keeps external table reads to external memory
// - programming mode tri-states all pwm outputs
module ccp_core
  import ccp_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        por_detect_i,
  output logic      [15:0] flash_addr_o,
  output logic             flash_rd_o,
  input  wire logic [7:0]  flash_data_i,
  output logic             cpu_reset_o,
  input  wire logic        clk_div_hi_i,
  input  wire logic        clk_div_lo_i,
  output logic             cpu_clk_en_o,
  input  wire logic        clk_out_enable_i,
  input  wire logic        idle_i,
  output logic             crystal_out_clock_pin_o,
  output logic             crystal_out_clock_oe_n_o,
  output logic             crystal_osc_en_o,
  output logic             rc_osc_en_o,
  output logic             rc_fast_o,
  output logic             ext_clk_sel_o,
  input  wire logic        por_flag_clr_i,
  output logic             por_flag_o,
  input  wire logic [1:0]  runtime_brownout_level_i,
  input  wire logic        brownout_reset_mode_i,
  input  wire logic        low_power_brownout_enable_i,
  input  wire logic        slow_rc_tick_i,
  input  wire logic        supply_low_i,
  output logic [1:0]       brownout_trip_level_o,
  output logic             brownout_sense_en_o,
  output logic             brownout_irq_o,
  output logic             wdt_clk_cpu_o,
  output logic             port_quasi_o,
  output logic             port_high_o,
  output logic             filter_enable_o,
  output logic             code_locked_o,
  output logic             data_locked_o,
  output logic             bank_erase_ok_o,
  input  wire logic        in_circuit_programming_i,
  input  wire logic        ext_code_access_i,
  input  wire logic        ext_data_access_i,
  output logic             ext_code_grant_o,
  output logic             ext_data_grant_o,
  output logic             ext_cfg_grant_o,
  input  wire logic        movc_from_ext_i,
  output logic             movc_int_allow_o,
  input  wire logic [1:0]  pwm_i,
  output logic [1:0]       pwm_o,
  output logic [1:0]       pwm_oe_n_o
);

  function automatic logic [1:0] cfg_level(input logic [1:0] c);
    if (c[1]) begin
      cfg_level = BOL_2V6;
    end else if (c[0]) begin
      cfg_level = BOL_3V8;
    end else begin
      cfg_level = BOL_4V5;
    end
  endfunction

  function automatic logic [1:0] run_level(input logic [1:0] c);
    if (!c[1]) begin
      run_level = BOL_2V6;
    end else if (c[0]) begin
      run_level = BOL_4V5;
    end else begin
      run_level = BOL_3V8;
    end
  endfunction

  ccp_load_e  ld_r;
  logic       load0;
  logic       load1;
  logic [7:0] byte0;
  logic [7:0] byte1;
  ccp_cfg_s   cfg;
  logic       bod_active;
  logic       lvl_applied_r;
  logic [1:0] level_sel;

  // byte reads happen once per power-up; no write path exists
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ld_r <= CCP_LD_ADDR0;
    end else begin
      case (ld_r)
        CCP_LD_ADDR0: ld_r <= CCP_LD_ADDR1;
        CCP_LD_ADDR1: ld_r <= CCP_LD_DONE;
        default:      ld_r <= CCP_LD_DONE;
      endcase
    end
  end

  assign flash_rd_o   = (ld_r != CCP_LD_DONE);
  assign flash_addr_o = (ld_r == CCP_LD_ADDR0) ? CFG0_ADDR : CFG1_ADDR;
  assign load0        = (ld_r == CCP_LD_ADDR0);
  assign load1        = (ld_r == CCP_LD_ADDR1);

  // cpu stays in reset until both bytes are held
  assign cpu_reset_o = flash_rd_o ||
                       (bod_active && brownout_reset_mode_i && supply_low_i);

  ccp_cfg_hold u_hold0 (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .load_i (load0),
    .data_i (flash_data_i),
    .data_o (byte0)
  );

  ccp_cfg_hold u_hold1 (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .load_i (load1),
    .data_i (flash_data_i),
    .data_o (byte1)
  );

  always_comb begin
    cfg.wdt_clk_cpu   = byte0[CFG0_WDT_CLK_BIT];
    cfg.port_quasi    = byte0[CFG0_PORT_MODE_BIT];
    cfg.port_high     = byte0[CFG0_PORT_LEVEL_BIT];
    cfg.bod_enable    = byte0[CFG0_BOD_EN_BIT];
    cfg.filter_enable = byte0[CFG0_FILTER_BIT];
    cfg.osc_type      = {byte0[CFG0_OSC_HI_BIT], byte0[CFG0_OSC_LO_BIT]};
    // unsupported 10 treated as fully locked, the safe reading
    cfg.code_locked   = !(byte1[CFG1_CODE_LOCK_BIT] &&
                          byte1[CFG1_DATA_LOCK_BIT]);
    cfg.data_locked   = !byte1[CFG1_DATA_LOCK_BIT];
    cfg.bank_erase_ok = byte1[CFG1_CODE_LOCK_BIT] &&
                        byte1[CFG1_DATA_LOCK_BIT];
    cfg.rc_fast       = byte1[CFG1_RC_FREQ_BIT];
    cfg.bod_level     = cfg_level({byte1[CFG1_BOV_HI_BIT],
                                   byte1[CFG1_BOV_LO_BIT]});
    cfg.read_inhibit  = !byte1[CFG1_READ_INH_BIT];
  end

  // oscillator selection; reserved code enables nothing
  assign crystal_osc_en_o = (cfg.osc_type == OSC_CRYSTAL);
  assign rc_osc_en_o      = (cfg.osc_type == OSC_RC);
  assign ext_clk_sel_o    = (cfg.osc_type == OSC_EXT);
  assign rc_fast_o        = cfg.rc_fast;

  assign wdt_clk_cpu_o   = cfg.wdt_clk_cpu;
  assign port_quasi_o    = cfg.port_quasi;
  assign port_high_o     = cfg.port_high;
  assign filter_enable_o = cfg.filter_enable;
  assign code_locked_o   = cfg.code_locked;
  assign data_locked_o   = cfg.data_locked;
  assign bank_erase_ok_o = cfg.bank_erase_ok;

  // external access gating
  assign ext_code_grant_o = ext_code_access_i && !cfg.code_locked;
  assign ext_cfg_grant_o  = !cfg.code_locked && !cfg.data_locked;
  assign ext_data_grant_o = ext_data_access_i && !cfg.data_locked;

  // table read from external code may reach internal only if allowed
  assign movc_int_allow_o = !(cfg.read_inhibit && movc_from_ext_i);

  // cpu clock prescaler; peripherals use the same enable
  logic [DIV_W-1:0] div_cnt_r;
  logic [DIV_W-1:0] div_top;

  always_comb begin
    if (!clk_div_hi_i) begin
      div_top = '0;
    end else if (clk_div_lo_i) begin
      div_top = DIV_W'(DIV_SLOW - 1);
    end else begin
      div_top = DIV_W'(DIV_MID - 1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      div_cnt_r <= '0;
    end else if (div_cnt_r >= div_top) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  assign cpu_clk_en_o = (div_cnt_r >= div_top);

  // clock output: toggle every two cpu clocks gives a quarter rate
  logic [1:0] co_cnt_r;
  logic       co_r;
  logic       co_allowed;

  // idle stops the cpu, not the oscillator, so the output keeps running
  assign co_allowed = clk_out_enable_i &&
                      (rc_osc_en_o || ext_clk_sel_o) && !flash_rd_o;

  always_ff @(posedge mclk_i) begin
    if (rst_i || !co_allowed) begin
      co_cnt_r <= '0;
      co_r     <= 1'b0;
    end else if (cpu_clk_en_o) begin
      if (co_cnt_r == 2'(CLKOUT_HALF - 1)) begin
        co_cnt_r <= '0;
        co_r     <= !co_r;
      end else begin
        co_cnt_r <= co_cnt_r + 1'b1;
      end
    end
  end

  assign crystal_out_clock_pin_o = co_r;
  // external clock mode leaves the pin floating unless output is on
  assign crystal_out_clock_oe_n_o = !(co_allowed || crystal_osc_en_o);

  // power-on flag; a new detect wins over the clear
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      por_flag_o <= 1'b0;
    end else if (por_detect_i) begin
      por_flag_o <= 1'b1;
    end else if (por_flag_clr_i) begin
      por_flag_o <= 1'b0;
    end
  end

  // level comes from config until the runtime field first changes from its previous value
  logic [1:0] rt_prev_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lvl_applied_r <= 1'b0;
      rt_prev_r     <= '0;
    end else begin
      rt_prev_r <= runtime_brownout_level_i;
      if (!flash_rd_o && rt_prev_r != runtime_brownout_level_i) begin
        lvl_applied_r <= 1'b1;
      end
    end
  end

  assign level_sel = lvl_applied_r ? run_level(runtime_brownout_level_i)
                                   : cfg.bod_level;
  assign brownout_trip_level_o = level_sel;
  assign bod_active = cfg.bod_enable && !flash_rd_o;

  // low power duty cycle counted in slow rc ticks
  logic [LPB_W-1:0] lpb_cnt_r;
  logic             lpb_on_r;

  always_ff @(posedge mclk_i) begin
    if (rst_i || !low_power_brownout_enable_i || !supply_low_i) begin
      lpb_cnt_r <= '0;
      lpb_on_r  <= 1'b1;
    end else if (slow_rc_tick_i) begin
      if (lpb_on_r && lpb_cnt_r == LPB_W'(LPB_ON_PERIODS - 1)) begin
        lpb_cnt_r <= '0;
        lpb_on_r  <= 1'b0;
      end else if (!lpb_on_r &&
                   lpb_cnt_r == LPB_W'(LPB_OFF_PERIODS - 1)) begin
        lpb_cnt_r <= '0;
        lpb_on_r  <= 1'b1;
      end else begin
        lpb_cnt_r <= lpb_cnt_r + 1'b1;
      end
    end
  end

  assign brownout_sense_en_o = bod_active && lpb_on_r;

  // interrupt pulse on each crossing, when not in reset mode
  logic low_prev_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      low_prev_r     <= 1'b0;
      brownout_irq_o <= 1'b0;
    end else begin
      low_prev_r     <= supply_low_i;
      brownout_irq_o <= bod_active && !brownout_reset_mode_i &&
                        (low_prev_r != supply_low_i);
    end
  end

  // programming mode floats the pwm pins
  assign pwm_o      = pwm_i;
  assign pwm_oe_n_o = {2{in_circuit_programming_i}};

endmodule

// >>> ccp_core_assertions.sv
`timescale 1ns/1ns
module ccp_core_chk
  import ccp_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic [15:0] flash_addr_o,
  input wire logic        flash_rd_o,
  input wire logic        cpu_reset_o,
  input wire logic        clk_div_hi_i,
  input wire logic        clk_div_lo_i,
  input wire logic        cpu_clk_en_o,
  input wire logic        crystal_out_clock_pin_o,
  input wire logic        por_detect_i,
  input wire logic        por_flag_o,
  input wire logic        brownout_irq_o,
  input wire logic        code_locked_o,
  input wire logic        ext_code_grant_o,
  input wire logic        in_circuit_programming_i,
  input wire logic [1:0]  pwm_oe_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // gap since last enable; same_r drops on a divide change so a mixed
  // interval is never judged
  logic [9:0] gap_r;
  logic       same_r;
  always_ff @(posedge mclk_i) begin
    if (rst_i || cpu_clk_en_o)
      gap_r <= 10'h000;
    else
      gap_r <= gap_r + 10'h001;
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i || $changed({clk_div_hi_i, clk_div_lo_i}))
      same_r <= 1'b0;
    else if (cpu_clk_en_o)
      same_r <= 1'b1;
  end
  sequence s_load;
    flash_rd_o && flash_addr_o == CFG0_ADDR ##1
    flash_rd_o && flash_addr_o == CFG1_ADDR ##1 !flash_rd_o;
  endsequence
  sequence s_fast;
    !clk_div_hi_i && !cpu_reset_o;
  endsequence
  property p_load; $fell(rst_i) |-> s_load; endproperty
  a_load: assert property (p_load) else $error("load order");
  property p_once; !flash_rd_o |=> !flash_rd_o; endproperty
  a_once: assert property (p_once) else $error("late read");
  property p_hold; $fell(rst_i) |-> cpu_reset_o [*2]; endproperty
  a_hold: assert property (p_hold) else $error("early run");
  property p_base; s_fast |-> cpu_clk_en_o; endproperty
  a_base: assert property (p_base) else $error("div four");
  property p_gap;
    cpu_clk_en_o && clk_div_hi_i && same_r && $stable(clk_div_lo_i)
    |-> gap_r == (clk_div_lo_i ? 10'h0ff : 10'h00f);
  endproperty
  a_gap: assert property (p_gap) else $error("div gap");
  property p_clkout;
    s_fast [*4] ##0 $rose(crystal_out_clock_pin_o) ##1 s_fast [*2]
    |-> $fell(crystal_out_clock_pin_o) && $past(crystal_out_clock_pin_o);
  endproperty
  a_clkout: assert property (p_clkout) else $error("clk out");
  property p_por; por_detect_i |=> por_flag_o; endproperty
  a_por: assert property (p_por) else $error("por flag");
  property p_irq; brownout_irq_o |=> !brownout_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("irq width");
  property p_pwm; in_circuit_programming_i |-> pwm_oe_n_o == 2'h3; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm driven");
  property p_lock; code_locked_o |-> !ext_code_grant_o; endproperty
  a_lock: assert property (p_lock) else $error("lock grant");
endmodule

bind ccp_core ccp_core_chk ccp_core_chk_inst (
  .mclk_i, .rst_i, .flash_addr_o, .flash_rd_o, .cpu_reset_o,
  .clk_div_hi_i, .clk_div_lo_i, .cpu_clk_en_o, .crystal_out_clock_pin_o,
  .por_detect_i, .por_flag_o, .brownout_irq_o, .code_locked_o,
  .ext_code_grant_o, .in_circuit_programming_i, .pwm_oe_n_o
);

// >>> ccp_core_tb.sv
`timescale 1ns/1ns
module ccp_core_tb
  import ccp_pkg::*;
;
  logic        mclk_i, rst_i, por_detect_i, flash_rd_o, cpu_reset_o;
  logic        clk_div_hi_i, clk_div_lo_i, cpu_clk_en_o, clk_out_enable_i;
  logic        idle_i, crystal_out_clock_pin_o, crystal_out_clock_oe_n_o;
  logic        crystal_osc_en_o, rc_osc_en_o, rc_fast_o, ext_clk_sel_o;
  logic        por_flag_clr_i, por_flag_o, brownout_reset_mode_i;
  logic        low_power_brownout_enable_i, slow_rc_tick_i, supply_low_i;
  logic        brownout_sense_en_o, brownout_irq_o, wdt_clk_cpu_o;
  logic        port_quasi_o, port_high_o, filter_enable_o, code_locked_o;
  logic        data_locked_o, bank_erase_ok_o, in_circuit_programming_i;
  logic        ext_code_access_i, ext_data_access_i, ext_code_grant_o;
  logic        ext_data_grant_o, ext_cfg_grant_o, movc_from_ext_i;
  logic        movc_int_allow_o;
  logic [15:0] flash_addr_o;
  logic [7:0]  flash_data_i, cfg0, cfg1;
  logic [1:0]  runtime_brownout_level_i, brownout_trip_level_o, pwm_i;
  logic [1:0]  pwm_o, pwm_oe_n_o;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  ccp_core ccp_core_inst (
    .mclk_i, .rst_i, .por_detect_i, .flash_addr_o, .flash_rd_o,
    .flash_data_i, .cpu_reset_o, .clk_div_hi_i, .clk_div_lo_i,
    .cpu_clk_en_o, .clk_out_enable_i, .idle_i, .crystal_out_clock_pin_o,
    .crystal_out_clock_oe_n_o, .crystal_osc_en_o, .rc_osc_en_o, .rc_fast_o,
    .ext_clk_sel_o, .por_flag_clr_i, .por_flag_o, .runtime_brownout_level_i,
    .brownout_reset_mode_i, .low_power_brownout_enable_i, .slow_rc_tick_i,
    .supply_low_i, .brownout_trip_level_o, .brownout_sense_en_o,
    .brownout_irq_o, .wdt_clk_cpu_o, .port_quasi_o, .port_high_o,
    .filter_enable_o, .code_locked_o, .data_locked_o, .bank_erase_ok_o,
    .in_circuit_programming_i, .ext_code_access_i, .ext_data_access_i,
    .ext_code_grant_o, .ext_data_grant_o, .ext_cfg_grant_o, .movc_from_ext_i,
    .movc_int_allow_o, .pwm_i, .pwm_o, .pwm_oe_n_o
  );
  ccp_flash_model ccp_flash_model_inst (
    .mclk_i, .addr_i(flash_addr_o), .rd_i(flash_rd_o), .cfg0_i(cfg0),
    .cfg1_i(cfg1), .data_o(flash_data_i)
  );

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // generous ceiling, the whole sequence needs about 6400 cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic cy(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask

  task automatic chk(input string nm, input logic [11:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic boot(input logic [7:0] b0, b1);
    cfg0 = b0;
    cfg1 = b1;
    rst_i = 1'b1;
    cy(4);
    chk("erased_rc", 1'b1, rc_fast_o);
    rst_i = 1'b0;
    cy(3);
  endtask

  task automatic t_cfg();
    logic [7:0] b0 [4] = '{8'hed, 8'h10, 8'h4b, 8'ha6};
    logic [7:0] b1 [4] = '{8'he2, 8'h48, 8'ha6, 8'h1c};
    logic [1:0] lk;
    logic [1:0] os;
    for (int i = 0; i < 4; i++) begin
      in_circuit_programming_i = 1'b0;
      boot(b0[i], b1[i]);
      chk("pwm_on", 2'h0, pwm_oe_n_o);
      in_circuit_programming_i = 1'b1;
      cfg0 = ~b0[i];
      cfg1 = ~b1[i];
      cy(2);
      lk = b1[i][7:6];
      os = b0[i][1:0];
      chk("wdt", b0[i][7], wdt_clk_cpu_o);
      chk("quasi", b0[i][6], port_quasi_o);
      chk("high", b0[i][5], port_high_o);
      chk("filter", b0[i][2], filter_enable_o);
      chk("xtal", os == OSC_CRYSTAL, crystal_osc_en_o);
      chk("rc", os == OSC_RC, rc_osc_en_o);
      chk("ext", os == OSC_EXT, ext_clk_sel_o);
      chk("rc_fast", b1[i][5], rc_fast_o);
      chk("code_lk", lk != 2'h3, code_locked_o);
      chk("data_lk", !b1[i][6], data_locked_o);
      chk("erase", lk == 2'h3, bank_erase_ok_o);
      chk("code_gnt", lk == 2'h3, ext_code_grant_o);
      chk("data_gnt", b1[i][6], ext_data_grant_o);
      chk("cfg_gnt", lk == 2'h3, ext_cfg_grant_o);
      chk("movc", b1[i][1], movc_int_allow_o);
      chk("trip", b1[i][3] ? BOL_2V6 : b1[i][2] ? BOL_3V8 : BOL_4V5,
          brownout_trip_level_o);
      chk("pwm_oe", 2'h3, pwm_oe_n_o);
      chk("pwm", pwm_i, pwm_o);
      if (os == OSC_RC || os == OSC_EXT)
        chk("clk_oe", 1'b0, crystal_out_clock_oe_n_o);
      {ext_code_access_i, ext_data_access_i, movc_from_ext_i} = 3'h0;
      cy(1);
      chk("code_idle", 1'b0, ext_code_grant_o);
      chk("data_idle", 1'b0, ext_data_grant_o);
      chk("movc_int", 1'b1, movc_int_allow_o);
      {ext_code_access_i, ext_data_access_i, movc_from_ext_i} = 3'h7;
    end
    in_circuit_programming_i = 1'b0;
  endtask

  task automatic t_div();
    int n;
    int t;
    logic p;
    boot(8'hed, 8'he2);
    idle_i = 1'b1;
    for (int d = 0; d < 4; d++) begin
      {clk_div_hi_i, clk_div_lo_i} = 2'(d);
      cy(300);
      n = 0;
      t = 0;
      p = crystal_out_clock_pin_o;
      repeat (1024) begin
        n += int'(cpu_clk_en_o === 1'b1);
        cy(1);
        t += int'(crystal_out_clock_pin_o !== p);
        p = crystal_out_clock_pin_o;
      end
      chk("en_count", d < 2 ? 12'h400 : d == 2 ? 12'h040 : 12'h004,
          12'(n));
      chk("clk_out", d < 2 ? 12'h200 : d == 2 ? 12'h020 : 12'h002,
          12'(t));
      chk("idle_oe", 1'b0, crystal_out_clock_oe_n_o);
    end
    clk_out_enable_i = 1'b0;
    cy(2);
    chk("clk_off", 1'b1, crystal_out_clock_oe_n_o);
    chk("clk_low", 1'b0, crystal_out_clock_pin_o);
    clk_out_enable_i = 1'b1;
    {clk_div_hi_i, clk_div_lo_i, idle_i} = 3'h0;
  endtask

  task automatic t_por();
    por_detect_i = 1'b1;
    cy(1);
    por_detect_i = 1'b0;
    cy(3);
    chk("por_hold", 1'b1, por_flag_o);
    por_flag_clr_i = 1'b1;
    cy(1);
    chk("por_clr", 1'b0, por_flag_o);
    por_detect_i = 1'b1;
    cy(1);
    chk("por_both", 1'b1, por_flag_o);
    {por_detect_i, por_flag_clr_i} = 2'h0;
  endtask

  task automatic flip(input logic [11:0] e);
    int n = 0;
    supply_low_i = !supply_low_i;
    repeat (4) begin
      cy(1);
      n += int'(brownout_irq_o === 1'b1);
    end
    chk("irq_count", e, 12'(n));
  endtask

  task automatic t_bod();
    boot(8'h10, 8'h48);
    flip(12'h000);
    flip(12'h000);
    boot(8'hed, 8'he2);
    flip(12'h001);
    flip(12'h001);
    brownout_reset_mode_i = 1'b1;
    supply_low_i = 1'b1;
    cy(2);
    chk("bod_rst", 1'b1, cpu_reset_o);
    supply_low_i = 1'b0;
    cy(2);
    chk("bod_rel", 1'b0, cpu_reset_o);
    brownout_reset_mode_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      runtime_brownout_level_i = 2'(k) ^ 2'h2;
      cy(2);
      chk("rt_level", !runtime_brownout_level_i[1] ? BOL_2V6 :
          runtime_brownout_level_i[0] ? BOL_4V5 : BOL_3V8,
          brownout_trip_level_o);
    end
  endtask

  task automatic t_lp();
    int on = 0;
    int off = 0;
    // a tick every cycle keeps the 64/960 duty run short
    slow_rc_tick_i = 1'b1;
    low_power_brownout_enable_i = 1'b1;
    supply_low_i = 1'b1;
    while (brownout_sense_en_o === 1'b1 && on < 2000) begin
      on++;
      cy(1);
    end
    while (brownout_sense_en_o !== 1'b1 && off < 2000) begin
      off++;
      cy(1);
    end
    chk("lp_on", 12'h040, 12'(on));
    chk("lp_off", 12'h3c0, 12'(off));
    {slow_rc_tick_i, low_power_brownout_enable_i, supply_low_i} = 3'h0;
  endtask

  initial begin
    rst_i = 1'b1;
    {por_detect_i, por_flag_clr_i, brownout_reset_mode_i, idle_i} = 4'h0;
    {clk_div_hi_i, clk_div_lo_i, supply_low_i, slow_rc_tick_i} = 4'h0;
    {low_power_brownout_enable_i, in_circuit_programming_i} = 2'h0;
    {ext_code_access_i, ext_data_access_i, movc_from_ext_i} = 3'h7;
    clk_out_enable_i = 1'b1;
    runtime_brownout_level_i = 2'h0;
    pwm_i = 2'h1;
    cfg0 = 8'hff;
    cfg1 = 8'hff;
    t_cfg();
    t_div();
    t_por();
    t_bod();
    t_lp();
    end_of_test();
  end
endmodule

// >>> ccp_flash_model.sv
`timescale 1ns/1ns
module ccp_flash_model
  import ccp_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  cfg0_i,
  input  wire logic [7:0]  cfg1_i,
  output logic      [7:0]  data_o
);
  // idle bus churns so a stray capture never lands on a lucky value
  logic [7:0] junk_r = 8'ha5;
  always_ff @(posedge mclk_i)
    junk_r <= junk_r + 8'h3b;
  always_comb begin
    data_o = junk_r;
    if (rd_i && addr_i == CFG0_ADDR)
      data_o = cfg0_i;
    else if (rd_i && addr_i == CFG1_ADDR)
      data_o = cfg1_i;
  end
endmodule

// >>> ccp_pkg.sv
package ccp_pkg;

  // configuration byte addresses in flash
  localparam logic [15:0] CFG0_ADDR      = 16'hfb00;
  localparam logic [15:0] CFG1_ADDR      = 16'hfb01;

  // first byte field positions
  localparam int CFG0_WDT_CLK_BIT        = 7;
  localparam int CFG0_PORT_MODE_BIT      = 6;
  localparam int CFG0_PORT_LEVEL_BIT     = 5;
  localparam int CFG0_BOD_EN_BIT         = 3;
  localparam int CFG0_FILTER_BIT         = 2;
  localparam int CFG0_OSC_HI_BIT         = 1;
  localparam int CFG0_OSC_LO_BIT         = 0;

  // second byte field positions
  localparam int CFG1_CODE_LOCK_BIT      = 7;
  localparam int CFG1_DATA_LOCK_BIT      = 6;
  localparam int CFG1_RC_FREQ_BIT        = 5;
  localparam int CFG1_BOV_HI_BIT         = 3;
  localparam int CFG1_BOV_LO_BIT         = 2;
  localparam int CFG1_READ_INH_BIT       = 1;

  // erased flash reads all ones
  localparam logic [7:0] CFG_ERASED      = 8'hff;

  // oscillator type codes
  localparam logic [1:0] OSC_CRYSTAL     = 2'h0;
  localparam logic [1:0] OSC_RC          = 2'h1;
  localparam logic [1:0] OSC_RESERVED    = 2'h2;
  localparam logic [1:0] OSC_EXT         = 2'h3;

  // brownout level codes on the analog trim port
  localparam logic [1:0] BOL_2V6         = 2'h0;
  localparam logic [1:0] BOL_3V8         = 2'h2;
  localparam logic [1:0] BOL_4V5         = 2'h3;

  // clocks per machine cycle, as cpu clock prescale ratios
  localparam int CPM_BASE                = 4;
  localparam int CPM_MID                 = 64;
  localparam int CPM_SLOW                = 1024;
  localparam int DIV_MID                 = CPM_MID / CPM_BASE;
  localparam int DIV_SLOW                = CPM_SLOW / CPM_BASE;
  localparam int DIV_W                   = 8;

  // clock output is cpu clock divided by four
  localparam int CLKOUT_RATIO            = 4;
  localparam int CLKOUT_HALF             = CLKOUT_RATIO / 2;

  // low power brownout duty in slow rc periods
  localparam int LPB_ON_PERIODS          = 64;
  localparam int LPB_OFF_PERIODS         = 960;
  localparam int LPB_W                   = 10;

  typedef enum logic [1:0] {
    CCP_LD_ADDR0,
    CCP_LD_ADDR1,
    CCP_LD_DONE
  } ccp_load_e;

  typedef struct packed {
    logic       wdt_clk_cpu;
    logic       port_quasi;
    logic       port_high;
    logic       bod_enable;
    logic       filter_enable;
    logic [1:0] osc_type;
    logic       code_locked;
    logic       data_locked;
    logic       bank_erase_ok;
    logic       rc_fast;
    logic [1:0] bod_level;
    logic       read_inhibit;
  } ccp_cfg_s;

endpackage
